// *** pmc_osc_model.sv ***
// Oscillator model answering the controller's enables with ready levels.
`timescale 1ns/1ps
module pmc_osc_model #(
  parameter int DLY = 3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic fastXtalOn,
  input wire logic fastRcOn,
  input wire logic slowXtalOn,
  input wire logic slowRcOn,
  output logic fastXtalReady,
  output logic fastRcReady,
  output logic slowXtalReady,
  output logic slowRcReady,
  output logic slowTick
);
  // ****
  // Start-up delay per oscillator; ready drops at once when stopped.
  // ****
  logic [3:0] on;
  logic [7:0] cnt_ff [4];
  logic [1:0] tk_ff;
  assign on = {fastXtalOn, fastRcOn, slowXtalOn, slowRcOn};
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (!reset_n || !on[i]) cnt_ff[i] <= 8'h0;
      else if (cnt_ff[i] != DLY[7:0]) cnt_ff[i] <= cnt_ff[i] + 8'h1;
    end
    tk_ff <= reset_n ? tk_ff + 2'h1 : 2'h0;
  end
  assign fastXtalReady = on[3] && cnt_ff[3] == DLY[7:0];
  assign fastRcReady = on[2] && cnt_ff[2] == DLY[7:0];
  assign slowXtalReady = on[1] && cnt_ff[1] == DLY[7:0];
  assign slowRcReady = on[0] && cnt_ff[0] == DLY[7:0];
  // The subclock stands still while both slow sources are stopped.
  assign slowTick = (on[1] || on[0]) && tk_ff == 2'h0;
endmodule

// *** pmc_pkg.sv ***
// Constants for the power mode and clock controller, and its oscillator flag.
// Notes on behaviour
// - Low-speed crystal speed-up bit is read-only and always reads one.
// - Enabling the low-speed crystal clears its stable flag until stable.
// - Low-speed crystal enable bit zero starts or stops the oscillator.
// - Bits seven to three of the crystal control register read zero.
// - Select code 111 in fast mode switches system clock to subclock.
// - Subclock source per source bit; it must be stable before switching.
// - Codes 000 to 110 in slow mode return to fast clock /1 to /64.
// - Halt with both keep-alive bits zero enters sleep; all clocks stop.
// - Halt with fast zero, slow one enters idle-zero; subclock runs.
// - Halt with both keep-alive bits one enters idle-one; both clocks run.
// - Halt with fast one, slow zero enters idle-two; subclock stops.
// - Low-power entry preserves memory, registers and port states.
// - Halt into low power sets power-down flag, clears timeout flag.
// - Halt clears the watchdog counter; it runs on only if enabled.
// - Wake on enabled port falling edge, interrupt or watchdog overflow.
// - Power-down flag clears only by power-up or clear-watchdog.
// - Watchdog overflow in low power sets timeout, resets PC and SP only.
// - Per-pin port wake enables; port wake resumes after the halt.
// - Interrupt wake takes normal response or resumes with request pending.
// - Interrupt already pending at halt entry cannot cause a wake-up.
// - Select field gives fast clock /1 to /64 or the subclock.
// - Source bit picks internal oscillator at zero, crystal at one.
// - Enabling a fast oscillator clears its flag until it is stable.
// - In sleep the slow internal oscillator runs only with watchdog enabled.
package pmc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_SYS_CLOCK_CONFIG = 12'h000;
  localparam logic [11:0] OFS_FAST_RC_CONTROL = 12'h004;
  localparam logic [11:0] OFS_FAST_XTAL_CONTROL = 12'h008;
  localparam logic [11:0] OFS_LOW_SPEED_CRYSTAL_CONTROL = 12'h00c;
  localparam logic [11:0] OFS_PORT_WAKE_ENABLE = 12'h010;
  localparam logic [11:0] OFS_POWER_STATUS = 12'h014;
  // Field positions in the clock configuration, oscillator control and power status registers.
  localparam int CFG_SEL_HI = 7;
  localparam int CFG_SEL_LO = 5;
  localparam int CFG_FAST_SRC = 3;
  localparam int CFG_SLOW_SRC = 2;
  localparam int CFG_FAST_KEEP = 1;
  localparam int CFG_SLOW_KEEP = 0;
  localparam int OSC_FREQ_HI = 3;
  localparam int OSC_FREQ_LO = 2;
  localparam int OSC_FLAG = 1;
  localparam int OSC_EN = 0;
  localparam int STAT_PDF = 0;
  localparam int STAT_TO = 1;
  // Reset values, the fixed speed-up bit and the select and divider codes.
  localparam logic [7:0] RST_SYS_CLOCK_CONFIG = 8'h00;
  localparam logic [1:0] RST_FAST_RC_FREQ = 2'h0;
  localparam logic RST_FAST_RC_EN = 1'b1;
  localparam logic RST_FAST_XTAL_EN = 1'b0;
  localparam logic RST_FAST_XTAL_MODE = 1'b0;
  localparam logic RST_SLOW_XTAL_EN = 1'b0;
  localparam logic SLOW_XTAL_SPEEDUP = 1'b1;
  localparam logic [2:0] SEL_SUBCLOCK = 3'h7;
  localparam logic [2:0] SEL_DIV_MAX = 3'h6;
  localparam logic [5:0] DIV_ONES = 6'h3f;
  // Cycles that an oscillator ready signal must hold before its flag sets.
  localparam int OSC_SETTLE_CYCLES = 16;
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_SLEEP = 3'b001,
    PMC_IDLE_ZERO_MODE = 3'b010,
    PMC_IDLE_ONE_MODE = 3'b011,
    PMC_IDLE_TWO_MODE = 3'b100,
    PMC_WAKE = 3'b101
  } pmc_mode_t;
endpackage

`timescale 1ns/1ps
// ****************************************************************
// Oscillator stable flag
// ****************************************************************
module pmc_osc_stable
  import pmc_pkg::*;
#(
  parameter int SETTLE = OSC_SETTLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic oscOn,
  input wire logic restart,
  input wire logic oscReady,
  output logic stableFlag
);
  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);
  logic [CW-1:0] cnt_ff;
  logic stable_ff;
  logic oscOnDly_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oscOnDly_ff <= 1'b0;
    end else begin
      oscOnDly_ff <= oscOn;
    end
  end

  // The flag drops when the oscillator starts or is retuned, then rises.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      stable_ff <= 1'b0;
    end else if (!oscOn || restart || (oscOn && !oscOnDly_ff)) begin
      cnt_ff <= '0;
      stable_ff <= 1'b0;
    end else if (!oscReady) begin
      cnt_ff <= '0;
    end else if (!stable_ff) begin
      if (cnt_ff == LAST) begin
        stable_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign stableFlag = stable_ff;
endmodule

// *** pmc_power_clock.sv ***
// Power mode and clock controller with an APB register slave.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module pmc_power_clock
  import pmc_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int INT_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltExec,
  input wire logic clrWdtExec,
  input wire logic wdtEnable,
  input wire logic wdtOverflow,
  input wire logic [PORT_W-1:0] portAIn,
  input wire logic [INT_W-1:0] intReq,
  input wire logic fastXtalReady,
  input wire logic fastRcReady,
  input wire logic slowXtalReady,
  input wire logic slowRcReady,
  input wire logic slowTick,
  output logic fastXtalOn,
  output logic fastRcOn,
  output logic slowXtalOn,
  output logic slowRcOn,
  output logic [1:0] fastRcFreq,
  output logic fastXtalMode,
  output logic [2:0] sysClkSel,
  output logic sysClkTick,
  output logic cpuRun,
  output logic wdtClear,
  output logic pcSpReset,
  output logic wakeByPort,
  output logic wakeByInt,
  output logic wakeByWdt,
  output logic [2:0] powerMode,
  output logic powerDownFlag,
  output logic watchdogTimeoutFlag
);
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [2:0] selReq_ff;
  logic fastSrc_ff;
  logic slowSrc_ff;
  logic fastKeep_ff;
  logic slowKeep_ff;
  logic [1:0] rcFreq_ff;
  logic rcEn_ff;
  logic xtalEn_ff;
  logic xtalMode_ff;
  logic slowXtalEn_ff;
  logic [PORT_W-1:0] portWake_ff;
  logic pdf_ff;
  logic to_ff;
  pmc_mode_t mode_ff;
  logic [2:0] selAct_ff;
  logic actSub_ff;
  logic [5:0] divCnt_ff;
  logic tick_ff;
  logic [PORT_W-1:0] portDly_ff;
  logic [INT_W-1:0] intBlock_ff;
  logic wdtClear_ff;
  logic pcSpReset_ff;
  logic wakePort_ff;
  logic wakeInt_ff;

  logic wrEn;
  logic rdEn;
  logic addrHit;
  logic fastXtalFlag;
  logic fastRcFlag;
  logic slowXtalFlag;
  logic slowRcFlag;
  logic fastFlag;
  logic subFlag;
  logic lowPower;
  logic fastStop;
  logic subStop;
  logic haltTake;
  logic portWakeEv;
  logic intWakeEv;
  logic wdtWakeEv;
  logic rcRestart;
  logic [5:0] divMask;
  logic [7:0] rdByte;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !pwrite;
  assign pready = 1'b1;
  assign lowPower = (mode_ff == PMC_SLEEP) || (mode_ff == PMC_IDLE_ZERO_MODE) ||
                    (mode_ff == PMC_IDLE_ONE_MODE) || (mode_ff == PMC_IDLE_TWO_MODE);
  assign haltTake = haltExec && (mode_ff == PMC_RUN);
  assign rcRestart = wrEn && (paddr == OFS_FAST_RC_CONTROL) &&
                     (pwdata[OSC_FREQ_HI:OSC_FREQ_LO] != rcFreq_ff);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      selReq_ff <= RST_SYS_CLOCK_CONFIG[CFG_SEL_HI:CFG_SEL_LO];
      fastSrc_ff <= RST_SYS_CLOCK_CONFIG[CFG_FAST_SRC];
      slowSrc_ff <= RST_SYS_CLOCK_CONFIG[CFG_SLOW_SRC];
      fastKeep_ff <= RST_SYS_CLOCK_CONFIG[CFG_FAST_KEEP];
      slowKeep_ff <= RST_SYS_CLOCK_CONFIG[CFG_SLOW_KEEP];
      rcFreq_ff <= RST_FAST_RC_FREQ;
      rcEn_ff <= RST_FAST_RC_EN;
      xtalEn_ff <= RST_FAST_XTAL_EN;
      xtalMode_ff <= RST_FAST_XTAL_MODE;
      slowXtalEn_ff <= RST_SLOW_XTAL_EN;
      portWake_ff <= '0;
    end else if (wrEn) begin
      case (paddr)
        OFS_SYS_CLOCK_CONFIG: begin
          selReq_ff <= pwdata[CFG_SEL_HI:CFG_SEL_LO];
          fastSrc_ff <= pwdata[CFG_FAST_SRC];
          slowSrc_ff <= pwdata[CFG_SLOW_SRC];
          fastKeep_ff <= pwdata[CFG_FAST_KEEP];
          slowKeep_ff <= pwdata[CFG_SLOW_KEEP];
        end
        OFS_FAST_RC_CONTROL: begin
          rcFreq_ff <= pwdata[OSC_FREQ_HI:OSC_FREQ_LO];
          rcEn_ff <= pwdata[OSC_EN];
        end
        OFS_FAST_XTAL_CONTROL: begin
          xtalEn_ff <= pwdata[OSC_EN];
          if (!xtalEn_ff) begin
            xtalMode_ff <= pwdata[OSC_FREQ_LO];
          end
        end
        OFS_LOW_SPEED_CRYSTAL_CONTROL: begin
          slowXtalEn_ff <= pwdata[OSC_EN];
        end
        OFS_PORT_WAKE_ENABLE: begin
          portWake_ff <= pwdata[PORT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb begin
    addrHit = 1'b1;
    rdByte = 8'h00;
    case (paddr)
      OFS_SYS_CLOCK_CONFIG: begin
        rdByte = {selReq_ff, 1'b0, fastSrc_ff, slowSrc_ff, fastKeep_ff,
                  slowKeep_ff};
      end
      OFS_FAST_RC_CONTROL: begin
        rdByte = {4'h0, rcFreq_ff, fastRcFlag, rcEn_ff};
      end
      OFS_FAST_XTAL_CONTROL: begin
        rdByte = {5'h00, xtalMode_ff, fastXtalFlag, xtalEn_ff};
      end
      OFS_LOW_SPEED_CRYSTAL_CONTROL: begin
        rdByte = {5'h00, SLOW_XTAL_SPEEDUP, slowXtalFlag,
                  slowXtalEn_ff};
      end
      OFS_PORT_WAKE_ENABLE: begin
        rdByte = 8'(portWake_ff);
      end
      OFS_POWER_STATUS: begin
        rdByte = {6'h00, to_ff, pdf_ff};
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  assign prdata = (rdEn && addrHit) ? {24'h000000, rdByte} : 32'h00000000;
  assign pslverr = psel && penable && !addrHit;

  // ****************************************************************
  // Oscillator control and stable flags
  // ****************************************************************
  assign fastStop = (mode_ff == PMC_SLEEP) || (mode_ff == PMC_IDLE_ZERO_MODE);
  assign subStop = (mode_ff == PMC_SLEEP) || (mode_ff == PMC_IDLE_TWO_MODE);
  assign fastXtalOn = xtalEn_ff && !fastStop;
  assign fastRcOn = rcEn_ff && !fastStop;
  assign slowXtalOn = slowXtalEn_ff && !subStop;
  assign slowRcOn = !subStop || wdtEnable;
  assign fastRcFreq = rcFreq_ff;
  assign fastXtalMode = xtalMode_ff;

  pmc_osc_stable u_fastXtal (
    .clk_sys(clk_sys), .reset_n(reset_n), .oscOn(fastXtalOn),
    .restart(1'b0), .oscReady(fastXtalReady), .stableFlag(fastXtalFlag)
  );
  pmc_osc_stable u_fastRc (
    .clk_sys(clk_sys), .reset_n(reset_n), .oscOn(fastRcOn),
    .restart(rcRestart), .oscReady(fastRcReady), .stableFlag(fastRcFlag)
  );
  pmc_osc_stable u_slowXtal (
    .clk_sys(clk_sys), .reset_n(reset_n), .oscOn(slowXtalOn),
    .restart(1'b0), .oscReady(slowXtalReady), .stableFlag(slowXtalFlag)
  );
  pmc_osc_stable u_slowRc (
    .clk_sys(clk_sys), .reset_n(reset_n), .oscOn(slowRcOn),
    .restart(1'b0), .oscReady(slowRcReady), .stableFlag(slowRcFlag)
  );

  assign fastFlag = fastSrc_ff ? fastXtalFlag : fastRcFlag;
  assign subFlag = slowSrc_ff ? slowXtalFlag : slowRcFlag;

  // ****************************************************************
  // Glitch-free system clock selection and divider
  // ****************************************************************
  // The active selection follows the request only once its target runs.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      selAct_ff <= RST_SYS_CLOCK_CONFIG[CFG_SEL_HI:CFG_SEL_LO];
      actSub_ff <= 1'b0;
    end else if (selReq_ff == SEL_SUBCLOCK) begin
      if (subFlag) begin
        selAct_ff <= selReq_ff;
        actSub_ff <= 1'b1;
      end
    end else if (fastFlag) begin
      selAct_ff <= selReq_ff;
      actSub_ff <= 1'b0;
    end
  end

  assign divMask = DIV_ONES >> (SEL_DIV_MAX - selAct_ff);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      divCnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (actSub_ff) begin
      tick_ff <= cpuRun && slowTick;
    end else begin
      divCnt_ff <= divCnt_ff + 1'b1;
      tick_ff <= cpuRun && fastFlag &&
                 ((divCnt_ff & divMask) == divMask);
    end
  end

  assign sysClkSel = selAct_ff;
  assign sysClkTick = tick_ff;

  // ****************************************************************
  // Operating mode sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      portDly_ff <= '0;
    end else begin
      portDly_ff <= portAIn;
    end
  end

  assign portWakeEv = |(portDly_ff & ~portAIn & portWake_ff);
  assign intWakeEv = |(intReq & ~intBlock_ff);
  assign wdtWakeEv = wdtOverflow;

  // Requests already raised at halt stay blocked from waking the device.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      intBlock_ff <= '0;
    end else if (haltTake) begin
      intBlock_ff <= intReq;
    end else if (!lowPower) begin
      intBlock_ff <= '0;
    end
  end

  // Only the mode changes here; register and port state are left alone.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_ff <= PMC_RUN;
    end else begin
      case (mode_ff)
        PMC_RUN: begin
          if (haltExec) begin
            case ({fastKeep_ff, slowKeep_ff})
              2'b00: mode_ff <= PMC_SLEEP;
              2'b01: mode_ff <= PMC_IDLE_ZERO_MODE;
              2'b11: mode_ff <= PMC_IDLE_ONE_MODE;
              default: mode_ff <= PMC_IDLE_TWO_MODE;
            endcase
          end
        end
        PMC_SLEEP, PMC_IDLE_ZERO_MODE, PMC_IDLE_ONE_MODE, PMC_IDLE_TWO_MODE: begin
          if (portWakeEv || intWakeEv || wdtWakeEv) begin
            mode_ff <= PMC_WAKE;
          end
        end
        PMC_WAKE: begin
          if (actSub_ff ? subFlag : fastFlag) begin
            mode_ff <= PMC_RUN;
          end
        end
        default: begin
          mode_ff <= PMC_RUN;
        end
      endcase
    end
  end

  assign cpuRun = (mode_ff == PMC_RUN);
  assign powerMode = mode_ff;

  // ****************************************************************
  // Status flags and wake pulses
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pdf_ff <= 1'b0;
    end else if (haltTake) begin
      pdf_ff <= 1'b1;
    end else if (clrWdtExec) begin
      pdf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      to_ff <= 1'b0;
    end else if (lowPower && wdtWakeEv) begin
      to_ff <= 1'b1;
    end else if (haltTake) begin
      to_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wdtClear_ff <= 1'b0;
      pcSpReset_ff <= 1'b0;
      wakePort_ff <= 1'b0;
      wakeInt_ff <= 1'b0;
    end else begin
      wdtClear_ff <= haltTake;
      pcSpReset_ff <= lowPower && wdtWakeEv;
      wakePort_ff <= lowPower && portWakeEv;
      wakeInt_ff <= lowPower && intWakeEv;
    end
  end

  assign wdtClear = wdtClear_ff;
  assign pcSpReset = pcSpReset_ff;
  assign wakeByPort = wakePort_ff;
  assign wakeByInt = wakeInt_ff;
  assign wakeByWdt = pcSpReset_ff;
  assign powerDownFlag = pdf_ff;
  assign watchdogTimeoutFlag = to_ff;
endmodule

// *** pmc_power_clock_assertions.sv ***
// Concurrent checks on the power mode and clock controller ports.
`timescale 1ns/1ps
module pmc_power_clock_assertions
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic haltExec,
  input wire logic clrWdtExec,
  input wire logic wdtEnable,
  input wire logic wdtOverflow,
  input wire logic fastXtalOn,
  input wire logic fastRcOn,
  input wire logic slowXtalOn,
  input wire logic slowRcOn,
  input wire logic sysClkTick,
  input wire logic cpuRun,
  input wire logic wdtClear,
  input wire logic pcSpReset,
  input wire logic wakeByPort,
  input wire logic wakeByInt,
  input wire logic wakeByWdt,
  input wire logic [2:0] powerMode,
  input wire logic powerDownFlag,
  input wire logic watchdogTimeoutFlag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic lowPwr;
  assign lowPwr = powerMode inside {3'h1, 3'h2, 3'h3, 3'h4};
  a_halt_flags: assert property (
    haltExec && powerMode == 3'h0 && !wdtOverflow |=> powerDownFlag
    && !watchdogTimeoutFlag && !cpuRun && wdtClear)
    else $error("halt entry flags wrong");
  a_sleep_clocks: assert property (
    powerMode == 3'h1 |-> !fastRcOn && !fastXtalOn && !slowXtalOn
    && slowRcOn == wdtEnable)
    else $error("sleep oscillator enables wrong");
  a_idle_zero_mode_fast: assert property (
    powerMode == 3'h2 |-> !fastRcOn && !fastXtalOn)
    else $error("idle zero fast clock running");
  a_idle_one_mode_both: assert property (
    powerMode == 3'h3 |-> (fastRcOn || fastXtalOn) && (slowRcOn || slowXtalOn))
    else $error("idle one clock stopped");
  a_idle_two_mode_sub: assert property (
    powerMode == 3'h4 |-> !slowXtalOn && (fastRcOn || fastXtalOn))
    else $error("idle two clocks wrong");
  a_pdf_clear: assert property (
    $fell(powerDownFlag) |-> $past(clrWdtExec))
    else $error("power down flag cleared without cause");
  a_wdt_wake: assert property (
    wdtOverflow && lowPwr |=> watchdogTimeoutFlag && pcSpReset && wakeByWdt
    && powerMode == 3'h5)
    else $error("watchdog wake wrong");
  a_wake_waits: assert property (
    wakeByPort || wakeByInt || wakeByWdt |-> powerMode == 3'h5 && !cpuRun)
    else $error("wake pulse outside wake state");
  a_sleep_tick: assert property (
    powerMode == 3'h1 ##1 powerMode == 3'h1 |-> !sysClkTick)
    else $error("system clock ticks in sleep");
  a_lxc_read: assert property (
    psel && !pwrite && paddr == OFS_LOW_SPEED_CRYSTAL_CONTROL
    |-> prdata[31:3] == 29'h0 && prdata[2])
    else $error("crystal control read bits wrong");
  c_port: cover property (wakeByPort);
  c_wdt: cover property (wakeByWdt);
  c_idle_one_mode: cover property (powerMode == 3'h3);
  c_int: cover property (wakeByInt);
endmodule
bind pmc_power_clock pmc_power_clock_assertions chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .haltExec(haltExec),
  .clrWdtExec(clrWdtExec), .wdtEnable(wdtEnable), .wdtOverflow(wdtOverflow),
  .fastXtalOn(fastXtalOn), .fastRcOn(fastRcOn), .slowXtalOn(slowXtalOn),
  .slowRcOn(slowRcOn), .sysClkTick(sysClkTick), .cpuRun(cpuRun),
  .wdtClear(wdtClear), .pcSpReset(pcSpReset), .wakeByPort(wakeByPort),
  .wakeByInt(wakeByInt), .wakeByWdt(wakeByWdt), .powerMode(powerMode),
  .powerDownFlag(powerDownFlag), .watchdogTimeoutFlag(watchdogTimeoutFlag));

// *** pmc_power_clock_tb.sv ***
// Self-checking bench for the power mode and clock controller.
`timescale 1ns/1ps
module pmc_power_clock_tb;
  import pmc_pkg::*;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic haltExec, clrWdtExec, wdtEnable, wdtOverflow, slowTick;
  logic [7:0] portAIn, intReq;
  logic fastXtalReady, fastRcReady, slowXtalReady, slowRcReady;
  logic fastXtalOn, fastRcOn, slowXtalOn, slowRcOn, fastXtalMode;
  logic sysClkTick, cpuRun, wdtClear, pcSpReset;
  logic wakeByPort, wakeByInt, wakeByWdt, powerDownFlag, watchdogTimeoutFlag;
  logic [1:0] fastRcFreq;
  logic [2:0] sysClkSel, powerMode;
  int n_fail, compares, n, i, k, s, b, w, t;
  pmc_power_clock dut_u (.*);
  pmc_osc_model #(.DLY(3)) osc_u (.*);
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int c;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (c >= 50) begin
      n_fail++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mode_of(input int kb);
    case (kb)
      0: mode_of = 1;
      1: mode_of = 2;
      2: mode_of = 4;
      default: mode_of = 3;
    endcase
  endfunction
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    n_fail++;
    $display("[FAIL] run expected done seen timeout");
    results();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {reset_n, psel, penable, pwrite, haltExec, clrWdtExec, wdtOverflow} = '0;
    paddr = '0;
    pwdata = '0;
    intReq = '0;
    portAIn = 8'hff;
    wdtEnable = 1'b1;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'hd31d));
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(0, OFS_SYS_CLOCK_CONFIG, 0);
    chk("cfg_rst", 32'h0, rd);
    apb(0, OFS_POWER_STATUS, 0);
    chk("stat_rst", 32'h0, rd);
    apb(0, 12'h020, 0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(1, OFS_LOW_SPEED_CRYSTAL_CONTROL, 32'hff);
    apb(0, OFS_LOW_SPEED_CRYSTAL_CONTROL, 0);
    chk("lxc_start", 32'h5, rd);
    chk("lxc_on", 1, slowXtalOn);
    n = 0;
    while (rd[1] !== 1'b1 && n < 40) begin
      apb(0, OFS_LOW_SPEED_CRYSTAL_CONTROL, 0);
      n++;
    end
    chk("lxc_stable", 32'h7, rd);
    apb(1, OFS_SYS_CLOCK_CONFIG, 32'he4);
    n = 0;
    while (sysClkSel !== 3'h7 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk("sel_sub", 7, sysClkSel);
    apb(1, OFS_FAST_XTAL_CONTROL, 32'h5);
    apb(1, OFS_FAST_RC_CONTROL, 32'h9);
    apb(0, OFS_FAST_XTAL_CONTROL, 0);
    chk("hxt_start", 32'h5, rd);
    chk("osc", 32'h1b, {pready, fastRcFreq, fastXtalMode, fastXtalOn});
    apb(0, OFS_FAST_RC_CONTROL, 0);
    chk("fast_internal_osc_retune", 32'h9, rd);
    for (i = 0; i < 3; i++) begin
      s = (i == 0) ? 6 : (i == 1) ? $urandom_range(1, 5) : 0;
      apb(1, OFS_SYS_CLOCK_CONFIG, (s << 5) | 32'h4 | (i == 2 ? 8 : 0));
      n = 0;
      while (sysClkSel !== s[2:0] && n < 200) begin
        @(posedge clk_sys);
        n++;
      end
      chk("sel_fast", s, sysClkSel);
      apb(0, OFS_FAST_RC_CONTROL, 0);
      chk("fast_internal_osc_flag", 1, rd[1]);
      t = 0;
      repeat (128) begin
        @(posedge clk_sys);
        if (sysClkTick === 1'b1) t++;
      end
      chk("ticks", 128 >> s, t);
    end
    for (i = 0; i < 8; i++) begin
      k = (i < 4) ? i : $urandom_range(0, 3);
      w = i % 3;
      b = $urandom_range(0, 7);
      apb(1, OFS_SYS_CLOCK_CONFIG, 32'h4 | k);
      apb(1, OFS_PORT_WAKE_ENABLE, ($urandom & 32'hff) | (32'h1 << b));
      @(posedge clk_sys);
      haltExec <= 1'b1;
      wdtEnable <= 1'($urandom_range(0, 1));
      if (i == 3) intReq <= 8'h1 << b;
      @(posedge clk_sys);
      haltExec <= 1'b0;
      @(negedge clk_sys);
      chk("mode", mode_of(k), powerMode);
      chk("flags", 3'b001, {cpuRun, watchdogTimeoutFlag, powerDownFlag});
      chk("fast_on", k[1], fastRcOn);
      chk("sub_on", k[0], slowXtalOn);
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("hold", mode_of(k), powerMode);
      @(posedge clk_sys);
      if (w == 0) portAIn[b] <= 1'b0;
      else if (w == 1) intReq[b] <= 1'b1;
      else wdtOverflow <= 1'b1;
      @(posedge clk_sys);
      wdtOverflow <= 1'b0;
      @(negedge clk_sys);
      chk("wake", 32'h1 << w, {wakeByWdt, wakeByInt, wakeByPort});
      chk("wake_mode", 5, powerMode);
      n = 0;
      while (cpuRun !== 1'b1 && n < 400) begin
        @(posedge clk_sys);
        n++;
      end
      chk("resume", 1, cpuRun);
      chk("to", w == 2, watchdogTimeoutFlag);
      chk("pdf_kept", 1, powerDownFlag);
      apb(0, OFS_SYS_CLOCK_CONFIG, 0);
      chk("cfg_kept", 32'h4 | k, rd);
      @(posedge clk_sys);
      portAIn <= 8'hff;
      intReq <= 8'h0;
      clrWdtExec <= 1'b1;
      @(posedge clk_sys);
      clrWdtExec <= 1'b0;
      @(negedge clk_sys);
      chk("pdf_clr", 0, powerDownFlag);
    end
    results();
  end
endmodule
